// ==== dv/fcs_flash_model.sv ====
// behavioural flash bank: command decoder, array, autoselect and status
`timescale 1ns/1ns
`default_nettype none

module fcs_flash_model #(
	parameter logic [15:0] MFR_ID   = 16'h00c1,
	parameter logic [15:0] DEV_ID   = 16'h0d2e,
	parameter logic [15:0] SEC_FILL = 16'h0f0f,
	parameter int          PROG_NS  = 300,
	parameter logic [3:0]  SUSP_SECT = 4'hf
) (
	input  wire logic        ce_n_i,
	input  wire logic        we_n_i,
	input  wire logic        oe_n_i,
	input  wire logic        hv_i,
	input  wire logic        byte_n_i,
	input  wire logic [21:0] addr_i,
	input  wire logic [15:0] dq_i,
	output logic [15:0]      dq_o,
	output logic             ready_busy_o
);
	logic [15:0] mem [256];
	logic [15:0] pd, last, rd;
	logic [11:0] a;
	logic [1:0]  step;
	logic        busy, exc, aut, sec, byp, arm, bx, susp;
	logic [7:0]  c;

	initial begin
		foreach (mem[i]) mem[i] = 16'hffff; // erased, readable at once
		{step, busy, exc, aut, sec, byp, arm, bx, susp} = '0;
		pd = '0;
		last = '0;
	end
	assign ready_busy_o = !busy;
	assign c = dq_i[7:0];
	always @(negedge we_n_i) a = addr_i[11:0];
	// data taken at the rising strobe, ce and oe qualify it
	always @(posedge we_n_i) if (!ce_n_i && oe_n_i) begin
		if (busy) begin
			if (exc && c == 8'hf0) {busy, exc} = '0;
		end else if (arm) begin
			pd = dq_i;
			arm = 0;
			busy = 1;
			exc = |(dq_i & ~mem[a[7:0]]);
			mem[a[7:0]] &= dq_i;
			// a failed raise stays busy until reset
			if (!exc) busy <= #(hv_i ? PROG_NS / 3 : PROG_NS) 1'b0;
		end else if (byp || hv_i) begin
			arm = c == 8'ha0;
			if (bx && c == 8'h00) byp = 0;
			bx = c == 8'h90;
		end else if (c == 8'hf0) {step, aut, arm} = '0;
		else if (!aut && step == 0 && c == 8'haa
			&& a == (byte_n_i ? 12'h555 : 12'haaa)) step = 1;
		else if (step == 1 && c == 8'h55
			&& a == (byte_n_i ? 12'h2aa : 12'h555)) step = 2;
		else if (step == 2) begin
			step = 0;
			case (c)
				8'h90: if (sec) step = 3; else aut = 1;
				8'ha0: arm = 1;
				8'h20: byp = !sec;
				8'h88: sec = 1;
				default: ;
			endcase
		end else if (step == 3 && c == 8'h00) {step, sec} = '0;
		else if (step == 0 && c == 8'hb0) susp = 1;
		else if (step == 0 && c == 8'h30) susp = 0;
		else step = 0;
	end
	always_comb begin
		rd = mem[addr_i[7:0]];
		if (busy) rd = {8'h00, ~pd[7], 1'b0, exc, 5'h00};
		else if (aut) rd = addr_i[1] ? 16'h0000 :
			(addr_i[0] ? DEV_ID : MFR_ID);
		else if (sec) rd = SEC_FILL;
		else if (susp && addr_i[7:4] == SUSP_SECT) rd = 16'h0080;
	end
	// released bus shows the inverse, never a stale copy
	always @(ce_n_i, oe_n_i, rd) begin
		dq_o = (!ce_n_i && !oe_n_i) ? rd : ~last;
		if (!ce_n_i && !oe_n_i) last = rd;
	end
endmodule : fcs_flash_model
`default_nettype wire

// ==== dv/fcs_host_assertions.sv ====
// port checks for the flash command sequencer
`timescale 1ns/1ns
`default_nettype none

module fcs_host_assertions (
	input wire logic               clk_i,
	input wire logic               rst_n_i,
	input wire logic               cmd_valid_i,
	input wire logic               cmd_ready_o,
	input wire logic               done_o,
	input wire logic               err_o,
	input wire fcs_pkg::fcs_mode_t mode_o,
	input wire logic [21:0]        flash_addr_o,
	input wire logic [15:0]        dq_o,
	input wire logic               dq_oe_o,
	input wire logic               ce_n_o,
	input wire logic               we_n_o,
	input wire logic               oe_n_o,
	input wire logic               hv_accel_o,
	input wire logic               rdata_valid_o,
	input wire logic               flash_busy_o,
	input wire logic               ready_busy_i
);
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!rst_n_i);

	chk_write_gate: assert property (
		!we_n_o |-> !ce_n_o && oe_n_o) else $error("bad write gate");
	chk_read_quiet: assert property (
		!oe_n_o |-> we_n_o && !dq_oe_o) else $error("read contention");
	chk_addr_setup: assert property (
		$fell(we_n_o) |-> $past(ce_n_o) == 1'b0 && dq_oe_o)
		else $error("no setup before strobe");
	chk_write_held: assert property (
		!we_n_o && $past(we_n_o) == 1'b0 |->
		$stable(flash_addr_o) && $stable(dq_o)) else $error("write moved");
	chk_data_hold: assert property (
		$rose(we_n_o) |-> !ce_n_o && dq_oe_o) else $error("data hold");
	chk_err_done: assert property (
		err_o |-> done_o) else $error("error without done");
	chk_one_at_time: assert property (
		cmd_valid_i && cmd_ready_o |=> !cmd_ready_o && !done_o)
		else $error("second command taken");
	chk_hv_from_read: assert property (
		$rose(hv_accel_o) |-> mode_o == fcs_pkg::MODE_READ)
		else $error("high voltage outside read mode");
	chk_valid_done: assert property (
		rdata_valid_o |=> done_o) else $error("read data without done");
	// two synchroniser flops plus the output flop
	chk_busy_follow: assert property (
		flash_busy_o == !$past(ready_busy_i, 3))
		else $error("busy flag does not follow the pin");

	cover property (done_o && err_o);
	cover property ($rose(hv_accel_o));
	cover property (mode_o == fcs_pkg::MODE_BYPASS);
endmodule : fcs_host_assertions

bind fcs_host fcs_host_assertions fcs_host_assertions_inst (.clk_i,
	.rst_n_i, .cmd_valid_i, .cmd_ready_o, .done_o, .err_o, .mode_o,
	.flash_addr_o, .dq_o, .dq_oe_o, .ce_n_o, .we_n_o, .oe_n_o, .hv_accel_o,
	.rdata_valid_o, .flash_busy_o, .ready_busy_i);
`default_nettype wire

// ==== dv/fcs_host_test.sv ====
// self-checking bench: sequencer against the behavioural flash
`timescale 1ns/1ns
`default_nettype none

module fcs_host_test;
	localparam logic [15:0] MFR = 16'h00c1; // arbitrary value
	localparam logic [15:0] DEV = 16'h0d2e; // arbitrary value
	logic              clk_i = 0, rst_n_i = 0, cmd_valid_i = 0;
	fcs_pkg::fcs_req_t cmd_i = '0;
	logic              cmd_ready_o, done_o, err_o, suspended_o, dq_oe_o;
	logic              ce_n_o, we_n_o, oe_n_o, hv_accel_o, rb;
	logic              hw_reset_n_o, byte_n_o, byte_mode_i = 0;
	logic [15:0]       rdata_o, dq_o, dq_fl, dq_w;
	logic [21:0]       flash_addr_o;
	fcs_pkg::fcs_mode_t mode_o;
	int                error_cnt = 0, n_compared = 0;

	always #5 clk_i = ~clk_i;
	assign dq_w = dq_oe_o ? dq_o : dq_fl;
	fcs_host #(.POLL_MAX(8)) fcs_host_inst (.clk_i, .rst_n_i, .cmd_valid_i,
		.cmd_i, .byte_mode_i, .cmd_ready_o, .done_o, .err_o, .rdata_o,
		.rdata_valid_o(), .mode_o, .suspended_o, .flash_busy_o(),
		.flash_addr_o, .dq_o, .dq_oe_o, .dq_i(dq_w), .ce_n_o, .we_n_o,
		.oe_n_o, .byte_n_o, .hv_accel_o, .hw_reset_n_o,
		.ready_busy_i(rb));
	fcs_flash_model #(.MFR_ID(MFR), .DEV_ID(DEV)) fcs_flash_model_inst (
		.ce_n_i(ce_n_o), .we_n_i(we_n_o), .oe_n_i(oe_n_o), .hv_i(hv_accel_o),
		.addr_i(flash_addr_o), .dq_i(dq_o), .dq_o(dq_fl), .ready_busy_o(rb),
		.byte_n_i(byte_n_o));

	task automatic check(string what, logic [15:0] seen, logic [15:0] exp);
		n_compared++;
		if (seen !== exp) begin
			error_cnt++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask : check

	task automatic finish_test();
		$display("compared %0d mismatches %0d", n_compared, error_cnt);
		if (error_cnt == 0 && n_compared > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask : finish_test

	// one command; err checked at done, mode settles one cycle later
	task automatic run(fcs_pkg::fcs_op_t op, logic [21:0] a,
		logic [15:0] d, logic acc, logic e);
		int n;
		n = 0;
		while (cmd_ready_o !== 1'b1 && n < 99) begin
			@(negedge clk_i);
			n++;
		end
		if (n >= 99) n = 3000; // a port that never readies is a timeout
		cmd_i = '{op, a, d, acc};
		cmd_valid_i = 1;
		@(negedge clk_i);
		cmd_valid_i = 0;
		while (done_o !== 1'b1 && n < 3000) begin
			@(negedge clk_i);
			n++;
		end
		if (n >= 3000) begin
			error_cnt++;
			finish_test();
		end
		check("err", {15'h0, err_o}, {15'h0, e});
		@(negedge clk_i);
	endtask : run

	initial begin
		repeat (8) @(negedge clk_i);
		check("hwrst", {15'h0, hw_reset_n_o}, 16'h0000);
		check("byten", {15'h0, byte_n_o}, 16'h0001);
		rst_n_i = 1;
		run(fcs_pkg::OP_READ, 22'h10, 0, 0, 0);
		check("array", rdata_o, 16'hffff);
		check("hwrst", {15'h0, hw_reset_n_o}, 16'h0001);
		run(fcs_pkg::OP_PROGRAM, 22'h10, 16'h1234, 0, 0);
		run(fcs_pkg::OP_READ, 22'h10, 0, 0, 0);
		check("prog", rdata_o, 16'h1234);
		run(fcs_pkg::OP_PROGRAM, 22'h10, 16'hffff, 0, 1);
		run(fcs_pkg::OP_READ, 22'h10, 0, 0, 0);
		check("zero", rdata_o, 16'h1234);
		run(fcs_pkg::OP_AUTOSEL, 22'h0, 0, 0, 0);
		check("mfr", rdata_o, MFR);
		check("mode", 16'(mode_o), 16'(fcs_pkg::MODE_AUTOSEL));
		run(fcs_pkg::OP_AUTOSEL, 22'h1, 0, 0, 0);
		check("dev", rdata_o, DEV);
		run(fcs_pkg::OP_AUTOSEL, 22'h2, 0, 0, 0);
		check("prot", rdata_o, 16'h0000);
		run(fcs_pkg::OP_PROGRAM, 22'h10, 16'h0, 0, 1);
		run(fcs_pkg::OP_RESET, 22'h0, 0, 0, 0);
		check("mode", 16'(mode_o), 16'(fcs_pkg::MODE_READ));
		run(fcs_pkg::OP_READ, 22'h10, 0, 0, 0);
		check("exit", rdata_o, 16'h1234);
		run(fcs_pkg::OP_BYP_ENTER, 22'h0, 0, 0, 0);
		check("mode", 16'(mode_o), 16'(fcs_pkg::MODE_BYPASS));
		run(fcs_pkg::OP_AUTOSEL, 22'h0, 0, 0, 1);
		run(fcs_pkg::OP_PROGRAM, 22'h11, 16'h00ff, 0, 0);
		run(fcs_pkg::OP_BYP_EXIT, 22'h0, 0, 0, 0);
		check("mode", 16'(mode_o), 16'(fcs_pkg::MODE_READ));
		run(fcs_pkg::OP_READ, 22'h11, 0, 0, 0);
		check("byp", rdata_o, 16'h00ff);
		run(fcs_pkg::OP_SEC_ENTER, 22'h0, 0, 0, 0);
		run(fcs_pkg::OP_READ, 22'h10, 0, 0, 0);
		check("sec", rdata_o, 16'h0f0f);
		run(fcs_pkg::OP_BYP_ENTER, 22'h0, 0, 0, 1);
		run(fcs_pkg::OP_PROGRAM, 22'h13, 16'h0, 1, 1);
		run(fcs_pkg::OP_SEC_EXIT, 22'h0, 0, 0, 0);
		run(fcs_pkg::OP_READ, 22'h10, 0, 0, 0);
		check("unsec", rdata_o, 16'h1234);
		run(fcs_pkg::OP_PROGRAM, 22'h13, 16'habcd, 1, 0);
		run(fcs_pkg::OP_READ, 22'h13, 0, 0, 0);
		check("acc", rdata_o, 16'habcd);
		run(fcs_pkg::OP_BYP_EXIT, 22'h0, 0, 0, 1);
		run(fcs_pkg::OP_SUSPEND, 22'h0, 0, 0, 0);
		check("susp", {15'h0, suspended_o}, 16'h0001);
		run(fcs_pkg::OP_READ, 22'hf0, 0, 0, 0);
		check("sread", rdata_o, 16'h0080);
		run(fcs_pkg::OP_READ, 22'h10, 0, 0, 0);
		check("sarray", rdata_o, 16'h1234);
		run(fcs_pkg::OP_RESUME, 22'h0, 0, 0, 0);
		check("resm", {15'h0, suspended_o}, 16'h0000);
		// byte width: unlocks must move to the byte addresses
		byte_mode_i = 1;
		@(negedge clk_i);
		check("byten", {15'h0, byte_n_o}, 16'h0000);
		run(fcs_pkg::OP_PROGRAM, 22'h14, 16'h005a, 0, 0);
		run(fcs_pkg::OP_READ, 22'h14, 0, 0, 0);
		check("bytep", rdata_o, 16'h005a);
		finish_test();
	end
endmodule : fcs_host_test
`default_nettype wire

// ==== src/fcs_host.sv ====
// host-side command sequencer driving an asynchronous parallel nor flash
// Behaviour
// R1 - array reads need no prior command
// R2 - bank returns to read after algorithm
// R3 - suspended sectors read status, others array
// R4 - host writes reset on timeout or autoselect
// R5 - reset returns bank to read/suspend-read
// R6 - reset aborts erase sequence before start
// R7 - reset aborts program sequence before start
// R8 - reset exits autoselect to prior read mode
// R9 - autoselect: two unlocks plus bank command
// R10 - autoselect only from read modes
// R11 - protection query needs bank and sector address
// R12 - three-cycle enter, four-cycle exit secured region
// R13 - secured region blocks bypass and acceleration
// R14 - program: unlocks, setup, address and data
// R15 - internal pulses; completion seen by polling
// R16 - commands ignored while programming runs
// R17 - no secured/autoselect while programming
// R18 - programming only clears ones to zeros
// R19 - unlocks plus 20h enter unlock bypass
// R20 - bypass program: A0h then address/data
// R21 - bypass accepts only program and exit
// R22 - high voltage only for accelerated programming
// R23 - address at later fall, data earlier rise
// R24 - write only with select, strobe low, oe high
// R25 - B0h suspends a sector erase
// R26 - customary unlock pairs per bus width
`timescale 1ns/1ns
`default_nettype none

module fcs_host #(
	parameter int POLL_MAX = 4000
) (
	input  wire logic                       clk_i,
	input  wire logic                       rst_n_i,
	input  wire logic                       cmd_valid_i,
	input  wire fcs_pkg::fcs_req_t          cmd_i,
	input  wire logic                       byte_mode_i,
	output logic                            cmd_ready_o,
	output logic                            done_o,
	output logic                            err_o,
	output logic [fcs_pkg::DATA_W-1:0]      rdata_o,
	output logic                            rdata_valid_o,
	output fcs_pkg::fcs_mode_t              mode_o,
	output logic                            suspended_o,
	output logic                            flash_busy_o,
	output logic [fcs_pkg::ADDR_W-1:0]      flash_addr_o,
	output logic [fcs_pkg::DATA_W-1:0]      dq_o,
	output logic                            dq_oe_o,
	input  wire logic [fcs_pkg::DATA_W-1:0] dq_i,
	output logic                            ce_n_o,
	output logic                            we_n_o,
	output logic                            oe_n_o,
	output logic                            byte_n_o,
	output logic                            hv_accel_o,
	output logic                            hw_reset_n_o,
	input  wire logic                       ready_busy_i
);

	typedef enum logic [2:0] {
		S_IDLE, S_HV, S_WSET, S_WLOW, S_WHIGH, S_RLOW, S_GAP, S_DONE
	} fcs_state_t;

	fcs_state_t             state_q;
	fcs_pkg::fcs_req_t      req_q;
	fcs_pkg::fcs_mode_t     mode_q;
	fcs_pkg::fcs_cyc_t      cyc;
	logic [2:0]             idx_q;
	logic [fcs_pkg::CNT_W-1:0] cnt_q;
	logic [15:0]            poll_q;
	logic                   bypass_q;
	logic                   recover_q;
	logic                   tout_seen_q;
	logic                   fail_q;
	logic [fcs_pkg::DATA_W-1:0] dq_s1_q, dq_s2_q;
	logic                   rb_s1_q, rb_s2_q;

	// which command script step goes on the bus next
	function automatic fcs_pkg::fcs_cyc_t step_of(
		input fcs_pkg::fcs_op_t op,
		input logic             bypass,
		input logic             byte_w,
		input logic [2:0]       idx
	);
		fcs_pkg::fcs_cyc_t c;
		logic [fcs_pkg::LOW_W-1:0] u1;
		logic [fcs_pkg::LOW_W-1:0] u2;
		c = '0;
		u1 = byte_w ? fcs_pkg::UNL1_BYTE : fcs_pkg::UNL1_WORD; // [R26]
		u2 = byte_w ? fcs_pkg::UNL2_BYTE : fcs_pkg::UNL2_WORD;
		if (idx == 3'h0) begin
			c.low = u1;
			c.code = fcs_pkg::CODE_UNLOCK1;
		end else if (idx == 3'h1) begin
			c.low = u2;
			c.code = fcs_pkg::CODE_UNLOCK2;
		end
		unique case (op)
			fcs_pkg::OP_RESET: begin
				c = '{fcs_pkg::ADDR_ANY, 1'b0, 1'b0, 1'b0,
					fcs_pkg::CODE_RESET, 1'b1}; // [R5]
			end
			fcs_pkg::OP_AUTOSEL: begin
				if (idx == 3'h2)
					c = '{u1, 1'b1, 1'b0, 1'b0,
						fcs_pkg::CODE_AUTOSEL, 1'b1}; // [R9]
			end
			fcs_pkg::OP_PROGRAM: begin
				if (bypass) begin
					if (idx == 3'h0)
						c = '{fcs_pkg::ADDR_ANY, 1'b0, 1'b0, 1'b0,
							fcs_pkg::CODE_PROGRAM, 1'b0}; // [R20]
					else
						c = '{fcs_pkg::ADDR_ANY, 1'b0, 1'b1, 1'b1,
							fcs_pkg::CODE_ZERO, 1'b1};
				end else if (idx == 3'h2) begin
					c = '{u1, 1'b0, 1'b0, 1'b0,
						fcs_pkg::CODE_PROGRAM, 1'b0}; // [R14]
				end else if (idx == 3'h3) begin
					c = '{fcs_pkg::ADDR_ANY, 1'b0, 1'b1, 1'b1,
						fcs_pkg::CODE_ZERO, 1'b1};
				end
			end
			fcs_pkg::OP_BYP_ENTER: begin
				if (idx == 3'h2)
					c = '{u1, 1'b0, 1'b0, 1'b0,
						fcs_pkg::CODE_BYPASS, 1'b1}; // [R19]
			end
			fcs_pkg::OP_BYP_EXIT: begin
				c = '{fcs_pkg::ADDR_ANY, 1'b0, 1'b0, 1'b0,
					(idx == 3'h0) ? fcs_pkg::CODE_AUTOSEL
					: fcs_pkg::CODE_ZERO, idx != 3'h0}; // [R21]
			end
			fcs_pkg::OP_SEC_ENTER: begin
				if (idx == 3'h2)
					c = '{u1, 1'b0, 1'b0, 1'b0,
						fcs_pkg::CODE_SEC_IN, 1'b1}; // [R12]
			end
			fcs_pkg::OP_SEC_EXIT: begin
				if (idx == 3'h2)
					c = '{u1, 1'b0, 1'b0, 1'b0,
						fcs_pkg::CODE_AUTOSEL, 1'b0}; // [R12]
				else if (idx == 3'h3)
					c = '{fcs_pkg::ADDR_ANY, 1'b0, 1'b0, 1'b0,
						fcs_pkg::CODE_ZERO, 1'b1};
			end
			fcs_pkg::OP_SUSPEND: begin
				c = '{fcs_pkg::ADDR_ANY, 1'b1, 1'b0, 1'b0,
					fcs_pkg::CODE_SUSPEND, 1'b1}; // [R25]
			end
			fcs_pkg::OP_RESUME: begin
				c = '{fcs_pkg::ADDR_ANY, 1'b1, 1'b0, 1'b0,
					fcs_pkg::CODE_RESUME, 1'b1};
			end
			fcs_pkg::OP_READ: begin
				c.last = 1'b1;
			end
		endcase
		return c;
	endfunction : step_of

	// commands the current mode does not allow are refused at the port
	function automatic logic refused(
		input fcs_pkg::fcs_mode_t m,
		input fcs_pkg::fcs_req_t  r
	);
		logic bad;
		bad = 1'b0;
		unique case (m)
			fcs_pkg::MODE_SECURED: bad = (r.op == fcs_pkg::OP_BYP_ENTER)
				|| (r.op == fcs_pkg::OP_PROGRAM && r.accel); // [R13]
			fcs_pkg::MODE_BYPASS: bad = !(r.op == fcs_pkg::OP_PROGRAM
				|| r.op == fcs_pkg::OP_BYP_EXIT
				|| r.op == fcs_pkg::OP_READ); // [R21]
			fcs_pkg::MODE_AUTOSEL: bad = !(r.op == fcs_pkg::OP_READ
				|| r.op == fcs_pkg::OP_AUTOSEL
				|| r.op == fcs_pkg::OP_RESET); // [R4] [R10]
			fcs_pkg::MODE_READ: bad = (r.op == fcs_pkg::OP_BYP_EXIT)
				|| (r.op == fcs_pkg::OP_SEC_EXIT);
		endcase
		return bad;
	endfunction : refused

	assign cyc = step_of(recover_q ? fcs_pkg::OP_RESET : req_q.op,
		bypass_q, byte_mode_i, idx_q);

	// dq and ready/busy come from the flash's own timing, not ours
	always_ff @(posedge clk_i) begin
		dq_s1_q <= dq_i;
		dq_s2_q <= dq_s1_q;
		rb_s1_q <= ready_busy_i;
		rb_s2_q <= rb_s1_q;
	end

	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			flash_busy_o <= 1'b0;
			hw_reset_n_o <= 1'b0; // [R5]
			byte_n_o <= 1'b1;
		end else begin
			flash_busy_o <= !rb_s2_q; // [R15]
			hw_reset_n_o <= 1'b1;
			byte_n_o <= !byte_mode_i; // [R26]
		end
	end

	// sequencer: one script of writes, then a read or a poll loop
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			state_q <= S_IDLE;
			req_q <= '0;
			idx_q <= '0;
			cnt_q <= '0;
			poll_q <= '0;
			bypass_q <= 1'b0;
			recover_q <= 1'b0;
			tout_seen_q <= 1'b0;
			fail_q <= 1'b0;
			cmd_ready_o <= 1'b0;
			done_o <= 1'b0;
			err_o <= 1'b0;
			rdata_o <= '0;
			rdata_valid_o <= 1'b0;
			flash_addr_o <= '0;
			dq_o <= '0;
			dq_oe_o <= 1'b0;
			ce_n_o <= 1'b1;
			we_n_o <= 1'b1;
			oe_n_o <= 1'b1;
			hv_accel_o <= 1'b0;
		end else begin
			done_o <= 1'b0;
			err_o <= 1'b0;
			rdata_valid_o <= 1'b0;
			cnt_q <= cnt_q + 1'b1;
			unique case (state_q)
				S_IDLE: begin
					// first read needs no command after reset [R1]
					cmd_ready_o <= 1'b1;
					ce_n_o <= 1'b1;
					oe_n_o <= 1'b1;
					dq_oe_o <= 1'b0;
					if (cmd_valid_i && cmd_ready_o) begin
						cmd_ready_o <= 1'b0;
						req_q <= cmd_i;
						idx_q <= '0;
						cnt_q <= '0;
						poll_q <= '0;
						tout_seen_q <= 1'b0;
						fail_q <= 1'b0;
						recover_q <= 1'b0;
						bypass_q <= (mode_q == fcs_pkg::MODE_BYPASS);
						if (refused(mode_q, cmd_i)) begin
							fail_q <= 1'b1;
							state_q <= S_DONE;
						end else if (cmd_i.op == fcs_pkg::OP_PROGRAM
							&& cmd_i.accel) begin
							bypass_q <= 1'b1;
							hv_accel_o <= 1'b1; // [R22]
							state_q <= S_HV;
						end else if (cmd_i.op == fcs_pkg::OP_READ
							|| (cmd_i.op == fcs_pkg::OP_AUTOSEL
							&& mode_q == fcs_pkg::MODE_AUTOSEL)) begin
							state_q <= S_GAP;
						end else begin
							state_q <= S_WSET;
						end
					end
				end
				S_HV: begin
					// pin settles at the high level before bypass writes
					if (cnt_q == fcs_pkg::CNT_W'(fcs_pkg::HV_CYC - 1)) begin
						cnt_q <= '0;
						state_q <= S_WSET;
					end
				end
				S_WSET: begin
					// address set up while the strobe is still high [R23]
					ce_n_o <= 1'b0;
					oe_n_o <= 1'b1;
					we_n_o <= 1'b1;
					dq_oe_o <= 1'b1;
					flash_addr_o <= cyc.user_addr ? req_q.addr
						: {cyc.bank ? req_q.addr[fcs_pkg::ADDR_W-1:
						fcs_pkg::LOW_W]
						: {(fcs_pkg::ADDR_W-fcs_pkg::LOW_W){1'b0}},
						cyc.low}; // [R11]
					dq_o <= cyc.user_data ? req_q.data
						: {8'h00, cyc.code};
					if (cnt_q == fcs_pkg::CNT_W'(fcs_pkg::AS_CYC - 1)) begin
						cnt_q <= '0;
						state_q <= S_WLOW;
					end
				end
				S_WLOW: begin
					we_n_o <= 1'b0; // [R24]
					// first edge only lowers the strobe, so count one more
					if (cnt_q == fcs_pkg::CNT_W'(fcs_pkg::WP_CYC)) begin
						cnt_q <= '0;
						we_n_o <= 1'b1; // data taken at this rise [R23]
						state_q <= S_WHIGH;
					end
				end
				S_WHIGH: begin
					ce_n_o <= 1'b1;
					if (cnt_q == fcs_pkg::CNT_W'(fcs_pkg::WPH_CYC - 1)) begin
						cnt_q <= '0;
						dq_oe_o <= 1'b0;
						idx_q <= idx_q + 1'b1;
						if (!cyc.last)
							state_q <= S_WSET;
						else if (!recover_q
							&& (req_q.op == fcs_pkg::OP_PROGRAM
							|| req_q.op == fcs_pkg::OP_AUTOSEL))
							state_q <= S_GAP; // [R15]
						else
							state_q <= S_DONE;
					end
				end
				S_GAP: begin
					cnt_q <= '0;
					flash_addr_o <= req_q.addr;
					state_q <= S_RLOW;
				end
				S_RLOW: begin
					ce_n_o <= 1'b0;
					oe_n_o <= 1'b0;
					// oe drops on the first edge; sample a full access later
					if (cnt_q == fcs_pkg::CNT_W'(fcs_pkg::ACC_CYC)) begin
						cnt_q <= '0;
						oe_n_o <= 1'b1;
						ce_n_o <= 1'b1;
						rdata_o <= dq_s2_q; // [R3]
						if (req_q.op != fcs_pkg::OP_PROGRAM) begin
							rdata_valid_o <= 1'b1;
							state_q <= S_DONE;
						end else if (dq_s2_q[fcs_pkg::DATA_POLL_BIT]
							== req_q.data[fcs_pkg::DATA_POLL_BIT]) begin
							// a stuck zero still reads back zero [R18]
							rdata_valid_o <= 1'b1;
							fail_q <= (dq_s2_q != req_q.data);
							state_q <= S_DONE; // [R2]
						end else if (tout_seen_q
							|| poll_q == 16'(POLL_MAX)) begin
							// host must clear the timeout itself [R4]
							recover_q <= 1'b1;
							fail_q <= 1'b1;
							idx_q <= '0;
							state_q <= S_WSET;
						end else begin
							tout_seen_q <= dq_s2_q[fcs_pkg::EXCEEDED_BIT];
							poll_q <= poll_q + 1'b1;
							state_q <= S_GAP; // [R16] [R17]
						end
					end
				end
				S_DONE: begin
					done_o <= 1'b1;
					err_o <= fail_q;
					hv_accel_o <= 1'b0; // [R22]
					cmd_ready_o <= 1'b1;
					state_q <= S_IDLE;
				end
				default: state_q <= S_IDLE;
			endcase
		end
	end

	// mode and suspend follow the completed command
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			mode_q <= fcs_pkg::MODE_READ;
			suspended_o <= 1'b0;
		end else if (state_q == S_DONE && !(fail_q && !recover_q)) begin
			unique case (recover_q ? fcs_pkg::OP_RESET : req_q.op)
				fcs_pkg::OP_RESET: begin
					if (mode_q == fcs_pkg::MODE_AUTOSEL || !recover_q)
						mode_q <= fcs_pkg::MODE_READ; // [R5] [R8]
				end
				fcs_pkg::OP_AUTOSEL: mode_q <= fcs_pkg::MODE_AUTOSEL;
				fcs_pkg::OP_BYP_ENTER: mode_q <= fcs_pkg::MODE_BYPASS;
				fcs_pkg::OP_BYP_EXIT: mode_q <= fcs_pkg::MODE_READ;
				fcs_pkg::OP_SEC_ENTER: mode_q <= fcs_pkg::MODE_SECURED;
				fcs_pkg::OP_SEC_EXIT: mode_q <= fcs_pkg::MODE_READ;
				fcs_pkg::OP_SUSPEND: suspended_o <= 1'b1; // [R25]
				fcs_pkg::OP_RESUME: suspended_o <= 1'b0;
				fcs_pkg::OP_READ, fcs_pkg::OP_PROGRAM: begin
				end
			endcase
		end
	end

	always_ff @(posedge clk_i) begin
		if (!rst_n_i)
			mode_o <= fcs_pkg::MODE_READ;
		else
			mode_o <= mode_q;
	end

endmodule : fcs_host

`default_nettype wire

// ==== src/fcs_pkg.sv ====
// constants, commands and carriers for the flash command sequencer
package fcs_pkg;

	localparam int ADDR_W = 22;
	localparam int DATA_W = 16;
	localparam int LOW_W  = 12;

	// bus timing in ns at the system clock
	localparam int CLK_NS   = 10;
	localparam int T_AS_NS  = 10;
	localparam int T_WP_NS  = 35;
	localparam int T_WPH_NS = 25;
	localparam int T_ACC_NS = 70;
	localparam int T_HV_NS  = 250;
	localparam int SYNC_CYC = 2;

	// least times round up to whole cycles
	localparam int AS_CYC  = (T_AS_NS + CLK_NS - 1) / CLK_NS;
	localparam int WP_CYC  = (T_WP_NS + CLK_NS - 1) / CLK_NS;
	localparam int WPH_CYC = (T_WPH_NS + CLK_NS - 1) / CLK_NS;
	localparam int ACC_CYC = (T_ACC_NS + CLK_NS - 1) / CLK_NS + SYNC_CYC;
	localparam int HV_CYC  = (T_HV_NS + CLK_NS - 1) / CLK_NS;
	localparam int CNT_W   = 8;

	// command codes on the low data byte
	localparam logic [7:0] CODE_UNLOCK1  = 8'haa;
	localparam logic [7:0] CODE_UNLOCK2  = 8'h55;
	localparam logic [7:0] CODE_AUTOSEL  = 8'h90;
	localparam logic [7:0] CODE_PROGRAM  = 8'ha0;
	localparam logic [7:0] CODE_BYPASS   = 8'h20;
	localparam logic [7:0] CODE_RESET    = 8'hf0;
	localparam logic [7:0] CODE_SUSPEND  = 8'hb0;
	localparam logic [7:0] CODE_RESUME   = 8'h30;
	localparam logic [7:0] CODE_SEC_IN   = 8'h88;
	localparam logic [7:0] CODE_ZERO     = 8'h00;

	// unlock addresses for word and byte bus width
	localparam logic [11:0] UNL1_WORD = 12'h555;
	localparam logic [11:0] UNL2_WORD = 12'h2aa;
	localparam logic [11:0] UNL1_BYTE = 12'haaa;
	localparam logic [11:0] UNL2_BYTE = 12'h555;
	localparam logic [11:0] ADDR_ANY  = 12'h000;

	// status bit positions on the data bus
	localparam int DATA_POLL_BIT = 7;
	localparam int EXCEEDED_BIT  = 5;

	typedef enum logic [3:0] {
		OP_READ,
		OP_RESET,
		OP_AUTOSEL,
		OP_PROGRAM,
		OP_BYP_ENTER,
		OP_BYP_EXIT,
		OP_SEC_ENTER,
		OP_SEC_EXIT,
		OP_SUSPEND,
		OP_RESUME
	} fcs_op_t;

	typedef enum logic [1:0] {
		MODE_READ,
		MODE_AUTOSEL,
		MODE_BYPASS,
		MODE_SECURED
	} fcs_mode_t;

	typedef struct packed {
		fcs_op_t             op;
		logic [ADDR_W-1:0]   addr;
		logic [DATA_W-1:0]   data;
		logic                accel;
	} fcs_req_t;

	// one bus write of a command script
	typedef struct packed {
		logic [LOW_W-1:0] low;
		logic             bank;
		logic             user_addr;
		logic             user_data;
		logic [7:0]       code;
		logic             last;
	} fcs_cyc_t;

endpackage : fcs_pkg
